// ===== power_monitor_pkg.sv
// Package of register map, field layout, reset values and timing constants for the power monitor core.
package power_monitor_pkg;

  // Register pointer values.
  localparam logic [7:0] REG_CONFIG      = 8'h00;
  localparam logic [7:0] REG_SENSE_VOLT  = 8'h01;
  localparam logic [7:0] REG_BUS_VOLT    = 8'h02;
  localparam logic [7:0] REG_POWER       = 8'h03;
  localparam logic [7:0] REG_CURRENT     = 8'h04;
  localparam logic [7:0] REG_CALIBRATION = 8'h05;

  // Configuration register field positions.
  localparam int CFG_SOFT_RESET_BIT = 15;
  localparam int CFG_AVG_LSB        = 9;
  localparam int CFG_BUS_CT_LSB     = 6;
  localparam int CFG_SENSE_CT_LSB   = 3;
  localparam int CFG_MODE_LSB       = 0;

  // Mode field: bit 2 selects continuous, bit 1 enables bus, bit 0 enables sense.
  localparam int MODE_CONT_BIT  = 2;
  localparam int MODE_BUS_BIT   = 1;
  localparam int MODE_SENSE_BIT = 0;

  // Values after reset.
  localparam logic [15:0] CONFIG_RESET      = 16'h4127;
  localparam logic [15:0] CALIBRATION_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET      = 16'h0000;

  // Serial bus slave address: upper bits fixed, low nibble from the address straps.
  localparam logic [2:0] SLAVE_ADDR_HI = 3'h4;

  // Conversion times in microseconds, selected by a 3-bit code.
  localparam int unsigned CONV_TIME_US [8] = '{139, 203, 331, 587, 1099, 2115, 4155, 8205};

  // Averaging counts and matching right shifts, selected by a 3-bit code.
  localparam int unsigned AVG_COUNT [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
  localparam int unsigned AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

  // Arithmetic scale factors.
  localparam int CURRENT_SHIFT = 11;
  localparam int POWER_DIVISOR = 20000;

  // Core clock rate in kHz; 10 MHz.
  localparam int unsigned CORE_CLK_KHZ = 10000;

  // Bus state machine.
  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_PTR, BUS_PTR_ACK,
    BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RDATA_ACK
  } bus_state_t;

  // Measurement sequencer.
  typedef enum logic [2:0] {
    MEAS_IDLE, MEAS_SENSE, MEAS_BUS, MEAS_CALC_I, MEAS_CALC_P
  } meas_state_t;

endpackage

// ===== current_power_monitor_core.sv
// Measurement core of the current and power monitor with its two-wire register port.
module current_power_monitor_core
  import power_monitor_pkg::*;
#(
  parameter int unsigned CLK_KHZ = CORE_CLK_KHZ
) (
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // Two-wire serial bus pins.
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  // Slave address straps, static during operation.
  input  wire logic [3:0]  i_addr_sel,
  // Converter sample words: sense in 2.5 uV steps, bus in 1.25 mV steps.
  input  wire logic [15:0] i_sense_code,
  input  wire logic [15:0] i_bus_code
);

  // Conversion time in core cycles for a 3-bit code, never below one cycle.
  function automatic logic [19:0] conv_cycles(input logic [2:0] code);
    int unsigned cyc;
    cyc = CONV_TIME_US[code] * CLK_KHZ / 1000;
    if (cyc == 0) begin
      cyc = 1;
    end
    return 20'(cyc - 1);
  endfunction

  // First channel to convert for a mode.
  function automatic meas_state_t first_channel(input logic [2:0] mode);
    return mode[MODE_SENSE_BIT] ? MEAS_SENSE : MEAS_BUS;
  endfunction

  // Complete module state.
  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic        scl_f;
    logic        sda_f;
    bus_state_t  bst;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  txsh;
    logic [7:0]  ptr;
    logic [7:0]  wbuf;
    logic        rw;
    logic        byte_lo;
    logic        nack;
    logic        sda_oe;
    logic [15:0] tx_word;
    meas_state_t mst;
    logic [19:0] tmr;
    logic [10:0] avg_cnt;
    logic [31:0] acc;
    logic [15:0] cfg;
    logic [15:0] cal;
    logic [15:0] sense;
    logic [15:0] bus;
    logic [15:0] cur;
    logic [15:0] pwr;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Open-drain data line: only ever pulled low.
  assign o_sda_o  = 1'b0;
  assign o_sda_oe = s_q.sda_oe;

  // Next-state logic for bus slave, register file and measurement sequencer.
  always_comb begin
    logic               scl_new;
    logic               sda_new;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_c;
    logic               stop_c;
    logic               wr_en;
    logic [15:0]        wr_data;
    logic [15:0]        rd_word;
    logic [2:0]         mode;
    logic [2:0]         ct_code;
    logic [2:0]         avg_code;
    logic [31:0]        sample;
    logic [31:0]        acc_sum;
    logic signed [32:0] cur_prod;
    logic signed [32:0] pwr_prod;
    logic signed [32:0] pwr_quot;
    s_d      = s_q;
    wr_en    = 1'b0;
    wr_data  = 16'h0000;
    rd_word  = 16'h0000;
    mode     = s_q.cfg[CFG_MODE_LSB +: 3];
    avg_code = s_q.cfg[CFG_AVG_LSB +: 3];
    ct_code  = 3'h0;
    sample   = 32'h0000_0000;
    acc_sum  = 32'h0000_0000;
    cur_prod = '0;
    pwr_prod = '0;
    pwr_quot = '0;

    // Pin filters: a level counts once the second and third stages agree.
    s_d.scl_s = {s_q.scl_s[1:0], i_scl};
    s_d.sda_s = {s_q.sda_s[1:0], i_sda};
    scl_new   = (s_q.scl_s[2] == s_q.scl_s[1]) ? s_q.scl_s[2] : s_q.scl_f;
    sda_new   = (s_q.sda_s[2] == s_q.sda_s[1]) ? s_q.sda_s[2] : s_q.sda_f;
    s_d.scl_f = scl_new;
    s_d.sda_f = sda_new;
    scl_rise  = scl_new & ~s_q.scl_f;
    scl_fall  = ~scl_new & s_q.scl_f;
    start_c   = s_q.scl_f & scl_new & s_q.sda_f & ~sda_new;
    stop_c    = s_q.scl_f & scl_new & ~s_q.sda_f & sda_new;

    // Read mux for the selected pointer; unmapped pointers read zero.
    unique case (s_q.ptr)
      REG_CONFIG:      rd_word = s_q.cfg;
      REG_SENSE_VOLT:  rd_word = s_q.sense;
      REG_BUS_VOLT:    rd_word = s_q.bus;
      REG_POWER:       rd_word = s_q.pwr;
      REG_CURRENT:     rd_word = s_q.cur;
      REG_CALIBRATION: rd_word = s_q.cal;
      default:         rd_word = 16'h0000;
    endcase

    // Serial slave: start and stop override any bit activity.
    if (start_c) begin
      s_d.bst     = BUS_ADDR;
      s_d.bit_cnt = 4'h0;
      s_d.sda_oe  = 1'b0;
    end else if (stop_c) begin
      s_d.bst    = BUS_IDLE;
      s_d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      // Sample incoming bits on the rising clock.
      unique case (s_q.bst)
        BUS_ADDR, BUS_PTR, BUS_WDATA: begin
          s_d.shreg   = {s_q.shreg[6:0], sda_new};
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end
        BUS_RDATA: begin
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end
        BUS_RDATA_ACK: begin
          s_d.nack = sda_new;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      // Drive acknowledges and read data on the falling clock.
      unique case (s_q.bst)
        BUS_IDLE: begin
        end
        BUS_ADDR: begin
          if (s_q.bit_cnt == 4'h8) begin
            if (s_q.shreg[7:1] == {SLAVE_ADDR_HI, i_addr_sel}) begin
              s_d.sda_oe = 1'b1;
              s_d.rw     = s_q.shreg[0];
              s_d.bst    = BUS_ADDR_ACK;
            end else begin
              s_d.bst = BUS_IDLE;
            end
          end
        end
        BUS_ADDR_ACK: begin
          s_d.bit_cnt = 4'h0;
          s_d.byte_lo = 1'b0;
          if (s_q.rw) begin
            // Snapshot the word so both bytes belong to one value.
            s_d.tx_word = rd_word;
            s_d.sda_oe  = ~rd_word[15];
            s_d.txsh    = {rd_word[14:8], 1'b0};
            s_d.bst     = BUS_RDATA;
          end else begin
            s_d.sda_oe = 1'b0;
            s_d.bst    = BUS_PTR;
          end
        end
        BUS_PTR: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d.ptr    = s_q.shreg;
            s_d.sda_oe = 1'b1;
            s_d.bst    = BUS_PTR_ACK;
          end
        end
        BUS_PTR_ACK: begin
          s_d.sda_oe  = 1'b0;
          s_d.bit_cnt = 4'h0;
          s_d.byte_lo = 1'b0;
          s_d.bst     = BUS_WDATA;
        end
        BUS_WDATA: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d.sda_oe = 1'b1;
            s_d.bst    = BUS_WDATA_ACK;
            if (!s_q.byte_lo) begin
              s_d.wbuf = s_q.shreg;
            end else begin
              wr_en   = 1'b1;
              wr_data = {s_q.wbuf, s_q.shreg};
            end
          end
        end
        BUS_WDATA_ACK: begin
          s_d.sda_oe  = 1'b0;
          s_d.bit_cnt = 4'h0;
          s_d.byte_lo = ~s_q.byte_lo;
          s_d.bst     = BUS_WDATA;
        end
        BUS_RDATA: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d.sda_oe = 1'b0;
            s_d.bst    = BUS_RDATA_ACK;
          end else begin
            s_d.sda_oe = ~s_q.txsh[7];
            s_d.txsh   = {s_q.txsh[6:0], 1'b0};
          end
        end
        BUS_RDATA_ACK: begin
          if (s_q.nack) begin
            s_d.bst = BUS_IDLE;
          end else begin
            // Second byte is the low half; further bytes repeat the word.
            s_d.byte_lo = ~s_q.byte_lo;
            s_d.bit_cnt = 4'h0;
            s_d.bst     = BUS_RDATA;
            if (!s_q.byte_lo) begin
              s_d.sda_oe = ~s_q.tx_word[7];
              s_d.txsh   = {s_q.tx_word[6:0], 1'b0};
            end else begin
              s_d.sda_oe = ~s_q.tx_word[15];
              s_d.txsh   = {s_q.tx_word[14:8], 1'b0};
            end
          end
        end
      endcase
    end

    // Measurement sequencer: conversion timer, averaging, then arithmetic.
    unique case (s_q.mst)
      MEAS_IDLE: begin
      end
      MEAS_SENSE, MEAS_BUS: begin
        if (s_q.tmr != 20'h0_0000) begin
          s_d.tmr = s_q.tmr - 20'h0_0001;
        end else begin
          // Sense accumulates signed, bus unsigned.
          sample  = (s_q.mst == MEAS_SENSE) ? {{16{i_sense_code[15]}}, i_sense_code}
                                            : {16'h0000, i_bus_code};
          acc_sum = s_q.acc + sample;
          ct_code = (s_q.mst == MEAS_SENSE) ? s_q.cfg[CFG_SENSE_CT_LSB +: 3] : s_q.cfg[CFG_BUS_CT_LSB +: 3];
          s_d.tmr = conv_cycles(ct_code);
          if (32'(s_q.avg_cnt) + 32'd1 >= AVG_COUNT[avg_code]) begin
            s_d.acc     = 32'h0000_0000;
            s_d.avg_cnt = 11'h000;
            // Average is a power-of-two divide; arithmetic shift keeps sign.
            if (s_q.mst == MEAS_SENSE) begin
              s_d.sense = 16'($signed(acc_sum) >>> AVG_SHIFT[avg_code]);
              if (mode[MODE_BUS_BIT]) begin
                s_d.mst = MEAS_BUS;
                s_d.tmr = conv_cycles(s_q.cfg[CFG_BUS_CT_LSB +: 3]);
              end else begin
                s_d.mst = MEAS_CALC_I;
              end
            end else begin
              s_d.bus = 16'(acc_sum >> AVG_SHIFT[avg_code]);
              s_d.mst = MEAS_CALC_I;
            end
          end else begin
            s_d.acc     = acc_sum;
            s_d.avg_cnt = s_q.avg_cnt + 11'h001;
          end
        end
      end
      MEAS_CALC_I: begin
        cur_prod = $signed(s_q.sense) * $signed({1'b0, s_q.cal});
        s_d.cur  = cur_prod[CURRENT_SHIFT +: 16];
        s_d.mst  = MEAS_CALC_P;
      end
      MEAS_CALC_P: begin
        pwr_prod = $signed({1'b0, s_q.bus}) * $signed(s_q.cur);
        pwr_quot = pwr_prod / 33'sd20000;
        s_d.pwr  = pwr_quot[15:0];
        // Continuous restarts at once; triggered waits for the next configuration write.
        if (mode[MODE_CONT_BIT]) begin
          s_d.mst = first_channel(mode);
          s_d.tmr = conv_cycles(mode[MODE_SENSE_BIT] ? s_q.cfg[CFG_SENSE_CT_LSB +: 3]
                                                      : s_q.cfg[CFG_BUS_CT_LSB +: 3]);
        end else begin
          s_d.mst = MEAS_IDLE;
        end
      end
      default: begin
        s_d.mst = MEAS_IDLE;
      end
    endcase

    // Register writes; a configuration write restarts or stops the sequencer.
    if (wr_en) begin
      unique case (s_q.ptr)
        REG_CONFIG: begin
          if (wr_data[CFG_SOFT_RESET_BIT]) begin
            s_d.cfg     = CONFIG_RESET;
            s_d.cal     = CALIBRATION_RESET;
            s_d.sense   = RESULT_RESET;
            s_d.bus     = RESULT_RESET;
            s_d.cur     = RESULT_RESET;
            s_d.pwr     = RESULT_RESET;
            mode        = CONFIG_RESET[CFG_MODE_LSB +: 3];
            wr_data     = CONFIG_RESET;
          end else begin
            s_d.cfg = wr_data;
            mode    = wr_data[CFG_MODE_LSB +: 3];
          end
          s_d.acc     = 32'h0000_0000;
          s_d.avg_cnt = 11'h000;
          // Mode with no channel enabled is shutdown.
          if (mode[MODE_BUS_BIT:MODE_SENSE_BIT] == 2'b00) begin
            s_d.mst = MEAS_IDLE;
          end else begin
            s_d.mst = first_channel(mode);
            s_d.tmr = conv_cycles(mode[MODE_SENSE_BIT] ? wr_data[CFG_SENSE_CT_LSB +: 3]
                                                        : wr_data[CFG_BUS_CT_LSB +: 3]);
          end
        end
        REG_CALIBRATION: begin
          s_d.cal = wr_data;
        end
        default: begin
        end
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_q         <= '0;
      s_q.scl_s   <= 3'h7;
      s_q.sda_s   <= 3'h7;
      s_q.scl_f   <= 1'b1;
      s_q.sda_f   <= 1'b1;
      s_q.bst     <= BUS_IDLE;
      s_q.cfg     <= CONFIG_RESET;
      s_q.cal     <= CALIBRATION_RESET;
      s_q.sense   <= RESULT_RESET;
      s_q.bus     <= RESULT_RESET;
      s_q.cur     <= RESULT_RESET;
      s_q.pwr     <= RESULT_RESET;
      s_q.mst     <= MEAS_SENSE;
      s_q.tmr     <= 20'h0_0000;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // current_power_monitor_core

// ===== current_power_monitor_core_asserts.sv
// Checker of the monitor core's serial pin behaviour, bound to the core.
module monitor_core_checker #(
  parameter int unsigned CLK_KHZ = 10000
) (
  // Clock and reset.
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  // Serial bus pins.
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic        o_sda_o,
  input wire logic        o_sda_oe,
  // Straps and converter samples.
  input wire logic [3:0]  i_addr_sel,
  input wire logic [15:0] i_sense_code,
  input wire logic [15:0] i_bus_code
);
  logic [9:0] oe_run_q;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  // Counts how long the data pin has been pulled low without a break.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      oe_run_q <= 10'h000;
    end else begin
      oe_run_q <= o_sda_oe ? oe_run_q + 10'h001 : 10'h000;
    end
  end

  // The open-drain data output only ever pulls low.
  a_sda_out_low: assert property (o_sda_o == 1'b0)
    else $error("data output value not low");
  // Reset releases the data pin on the next edge.
  a_oe_after_rst: assert property (disable iff (1'b0) i_sys_rst |=> !o_sda_oe)
    else $error("data pin driven after reset");
  // The pin drive changes only while the serial clock is low.
  a_oe_moves_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data pin drive changed with clock high");
  // An acknowledge or data bit drive is held for at least nine core cycles.
  a_ack_holds: assert property ($rose(o_sda_oe) |=> o_sda_oe [*8])
    else $error("data pin drive too short");
  // The drive starts promptly after the clock falls.
  a_oe_rise_prompt: assert property ($rose(o_sda_oe) |-> $past(i_scl, 6))
    else $error("data pin drive started late");
  // No drive stretches beyond one byte and its acknowledge.
  a_oe_run_bound: assert property (oe_run_q < 10'd400)
    else $error("data pin held low too long");
  // At a start condition the core is not driving.
  a_start_free: assert property (($fell(i_sda) && i_scl) |-> !o_sda_oe)
    else $error("data pin driven at start");
  // After a stop condition the core stays off the bus.
  a_stop_free: assert property (($rose(i_sda) && i_scl) |=> !o_sda_oe [*4])
    else $error("data pin driven after stop");

  // Main scenarios reached.
  c_ack: cover property ($rose(o_sda_oe));
  c_start: cover property ($fell(i_sda) && i_scl);
  c_long_read: cover property (oe_run_q > 10'd100);
endmodule // monitor_core_checker

bind current_power_monitor_core monitor_core_checker #(.CLK_KHZ(CLK_KHZ)) u_checker (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_addr_sel(i_addr_sel),
  .i_sense_code(i_sense_code), .i_bus_code(i_bus_code)
);

// ===== i2c_host_model.sv
// Behavioural two-wire bus master that talks to the monitor core.
module i2c_host_model (
  // Clock and bus wire.
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  // Drives of the bus lines: clock driven high and low, data only pulled low.
  output logic      o_scl,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 10;

  // The bus idles released.
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Waits whole core cycles, then steps just past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  // Start condition from an idle bus.
  task automatic start();
    o_sda_low = 1'b1;
    tick(HALF);
    o_scl = 1'b0;
  endtask

  // Stop condition; the clock is low on entry.
  task automatic stop();
    tick(HALF / 2);
    o_sda_low = 1'b1;
    tick(HALF / 2);
    o_scl = 1'b1;
    tick(HALF);
    o_sda_low = 1'b0;
    tick(HALF);
  endtask

  // One bit: data set in the low phase, sampled at the end of the high phase.
  task automatic bit_cycle(input logic b, output logic s);
    tick(HALF / 2);
    o_sda_low = !b;
    tick(HALF / 2);
    o_scl = 1'b1;
    tick(HALF);
    s = i_sda;
    o_scl = 1'b0;
  endtask

  // Byte out MSB first, then the ninth bit returns the acknowledge.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, s);
    ack = !s;
  endtask

  // Byte in MSB first, then the master answers ACK or NACK.
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, d[i]);
    end
    bit_cycle(!ack, s);
  endtask
endmodule // i2c_host_model

// ===== tb_current_power_monitor_core.sv
// Self-checking bench of the current and power monitor core.
module tb_current_power_monitor_core import power_monitor_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0]  addr_sel = 4'h5;
  logic [7:0]  dev_w;
  logic        i_core_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [15:0] sense_code;
  logic [15:0] bus_code;
  logic        scl;
  logic        host_low;
  logic        o_sda_o;
  logic        o_sda_oe;
  wire         sda;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;

  // Open-drain wire with pull-up.
  assign sda = !(host_low || o_sda_oe);

  // Write address byte of the core for the present strap setting.
  assign dev_w = {SLAVE_ADDR_HI, addr_sel, 1'b0};

  current_power_monitor_core #(.CLK_KHZ(100)) u_dut (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_addr_sel(addr_sel),
    .i_sense_code(sense_code), .i_bus_code(bus_code)
  );
  i2c_host_model u_host (.i_core_clk(i_core_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

  // 10 MHz clock and hang guard.
  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_ack(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Pointer byte then a high and a low data byte, each acknowledged.
  task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] d, input logic two = 1'b1);
    logic a0, a1, a2, a3;
    u_host.start();
    u_host.wr_byte(dev_w, a0);
    u_host.wr_byte(ptr, a1);
    a2 = 1'b1;
    a3 = 1'b1;
    if (two) begin
      u_host.wr_byte(d[15:8], a2);
      u_host.wr_byte(d[7:0], a3);
    end
    u_host.stop();
    chk_ack("write acks", 1'b1, a0 & a1 & a2 & a3);
  endtask

  // Sets the pointer, then reads the word it selects.
  task automatic chk_reg(input string what, input logic [7:0] ptr, input logic [15:0] exp);
    logic        a;
    logic [15:0] d;
    wr_reg(ptr, 16'h0000, 1'b0);
    u_host.start();
    u_host.wr_byte(dev_w | 8'h01, a);
    u_host.rd_byte(1'b1, d[15:8]);
    u_host.rd_byte(1'b0, d[7:0]);
    u_host.stop();
    chk_ack("read ack", 1'b1, a);
    chk_word(what, exp, d);
  endtask

  task automatic t_reset_values();
    logic a;
    chk_reg("config", REG_CONFIG, 16'h4127);
    chk_reg("calibration", REG_CALIBRATION, 16'h0000);
    chk_reg("current", REG_CURRENT, 16'h0000);
    chk_reg("power", REG_POWER, 16'h0000);
    chk_reg("unmapped", 8'h07, 16'h0000);
    u_host.start();
    u_host.wr_byte(8'h80, a);
    u_host.stop();
    chk_ack("foreign address", 1'b0, a);
  endtask

  // Calibration for a 2 mOhm shunt at 1 mA per count.
  task automatic t_example();
    wr_reg(REG_CALIBRATION, 16'h0A00);
    wr_reg(REG_SENSE_VOLT, 16'h1234);
    u_host.tick(300);
    chk_reg("sense", REG_SENSE_VOLT, 16'h1F40);
    chk_reg("bus", REG_BUS_VOLT, 16'h2580);
    chk_reg("current", REG_CURRENT, 16'h2710);
    chk_reg("power", REG_POWER, 16'h12C0);
  endtask

  task automatic t_reverse();
    sense_code = 16'hE0C0;
    u_host.tick(300);
    chk_reg("sense", REG_SENSE_VOLT, 16'hE0C0);
    chk_reg("current", REG_CURRENT, 16'hD8F0);
    chk_reg("power", REG_POWER, 16'hED40);
  endtask

  task automatic t_triggered();
    wr_reg(REG_CONFIG, 16'h4123);
    u_host.tick(300);
    sense_code = 16'h0FA0;
    bus_code = 16'h12C0;
    u_host.tick(300);
    chk_reg("held current", REG_CURRENT, 16'hD8F0);
    chk_reg("held bus", REG_BUS_VOLT, 16'h2580);
    wr_reg(REG_CONFIG, 16'h4123);
    u_host.tick(300);
    chk_reg("current", REG_CURRENT, 16'h1388);
    chk_reg("power", REG_POWER, 16'h04B0);
  endtask

  task automatic t_shutdown();
    wr_reg(REG_CONFIG, 16'h4120);
    sense_code = 16'h1F40;
    bus_code = 16'h2580;
    wr_reg(REG_CALIBRATION, 16'h1400);
    chk_reg("calibration", REG_CALIBRATION, 16'h1400);
    chk_reg("config", REG_CONFIG, 16'h4120);
    chk_reg("idle current", REG_CURRENT, 16'h1388);
    wr_reg(REG_CONFIG, 16'h4127);
    u_host.tick(300);
    chk_reg("current", REG_CURRENT, 16'h4E20);
    chk_reg("power", REG_POWER, 16'h2580);
  endtask

  task automatic t_soft_reset();
    wr_reg(REG_CONFIG, 16'hC120);
    chk_reg("config", REG_CONFIG, 16'h4127);
    chk_reg("calibration", REG_CALIBRATION, 16'h0000);
    chk_reg("current", REG_CURRENT, 16'h0000);
  endtask

  // Slowest times with four averages: the result lags, then equals the input.
  task automatic t_slow_avg();
    wr_reg(REG_CALIBRATION, 16'h0800);
    wr_reg(REG_CONFIG, 16'h43FF);
    sense_code = 16'h0123;
    chk_reg("lagging current", REG_CURRENT, 16'h1F40);
    u_host.tick(7000);
    chk_reg("averaged current", REG_CURRENT, 16'h0123);
  endtask

  // New strap address, then bus-only and sense-only continuous modes.
  task automatic t_straps_modes();
    logic a;
    addr_sel = 4'hA;
    wr_reg(REG_CONFIG, 16'h4126);
    sense_code = 16'h0FA0;
    bus_code = 16'h12C0;
    u_host.tick(300);
    chk_reg("bus only sense", REG_SENSE_VOLT, 16'h0123);
    chk_reg("bus only bus", REG_BUS_VOLT, 16'h12C0);
    chk_reg("bus only power", REG_POWER, 16'h0045);
    wr_reg(REG_CONFIG, 16'h4125);
    bus_code = 16'h2580;
    u_host.tick(300);
    chk_reg("sense only bus", REG_BUS_VOLT, 16'h12C0);
    chk_reg("sense only current", REG_CURRENT, 16'h0FA0);
    chk_reg("sense only power", REG_POWER, 16'h03C0);
    u_host.start();
    u_host.wr_byte(8'h8A, a);
    u_host.stop();
    chk_ack("old address", 1'b0, a);
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    sense_code = 16'h1F40;
    bus_code = 16'h2580;
    repeat (4) @(posedge i_core_clk);
    #1;
    i_sys_rst = 1'b0;
    u_host.tick(10);
    t_reset_values();
    t_example();
    t_reverse();
    t_triggered();
    t_shutdown();
    t_soft_reset();
    t_slow_avg();
    t_straps_modes();
    conclude();
  end
endmodule // tb_current_power_monitor_core
